// ---- hw/aiot_defines.vh ----
`ifndef AIOT_DEFINES_VH
`define AIOT_DEFINES_VH
`define AIOT_NSEQ           4
`define AIOT_AW             12
`define AIOT_OFF_RIS        12'h004
`define AIOT_OFF_MASK       12'h008
`define AIOT_OFF_ISC        12'h00c
`define AIOT_OFF_OVF        12'h010
`define AIOT_OFF_TRIG       12'h014
`define AIOT_OFF_EVSTAT     12'h040
`define AIOT_OFF_EVMASK     12'h044
`define AIOT_SEQ_LSB        0
`define AIOT_SEQ_MSB        3
`define AIOT_TRIG_MSB       15
`define AIOT_FLD_W          4
`define AIOT_RST3           3'h0
`define AIOT_RST4           4'h0
`define AIOT_RST8           8'h00
`define AIOT_EV_MSB         7
`define AIOT_RST16          16'h0000
`define AIOT_RST32          32'h00000000
`define AIOT_TRG_CPU        4'h0
`define AIOT_TRG_CMP0       4'h1
`define AIOT_TRG_PIN        4'h4
`define AIOT_TRG_TIMER      4'h5
`define AIOT_TRG_PWM0       4'h6
`define AIOT_TRG_PWM1       4'h7
`define AIOT_TRG_PWM2       4'h8
`define AIOT_TRG_ALWAYS     4'hf
`define AIOT_EV_OVF_LSB     0
`define AIOT_EV_RAW_LSB     4
`endif

// ---- hw/aiot_trig_decode.v ----
`timescale 1ns/1ps
`include "aiot_defines.vh"
// one sequencer's trigger multiplexer; all sequencers share this decode
module aiot_trig_decode (
  input  wire [3:0] sel,       // trigger field
  input  wire       cpu_req,   // processor request
  input  wire       cmp0_ev,   // comparator 0 event
  input  wire       pin_ev,    // external pin event (synchronised)
  input  wire       timer_ev,  // timer event
  input  wire [2:0] pwm_ev,    // pwm generator events
  output reg        start      // sample start request
);
  always @* begin
    case (sel)
      `AIOT_TRG_CPU:    start = cpu_req;
      `AIOT_TRG_CMP0:   start = cmp0_ev;
      `AIOT_TRG_PIN:    start = pin_ev;
      `AIOT_TRG_TIMER:  start = timer_ev;
      `AIOT_TRG_PWM0:   start = pwm_ev[0];
      `AIOT_TRG_PWM1:   start = pwm_ev[1];
      `AIOT_TRG_PWM2:   start = pwm_ev[2];
      `AIOT_TRG_ALWAYS: start = 1'b1;
      default:          start = 1'b0; // reserved codes never trigger
    endcase
  end
endmodule

// ---- hw/aiot_regs.v ----
`timescale 1ns/1ps
`include "aiot_defines.vh"
module aiot_regs #(
  parameter NSEQ = `AIOT_NSEQ
) (
  input  wire                  clk_sys,      // 100 MHz clock
  input  wire                  rst,          // synchronous reset, active high
  input  wire [`AIOT_AW-1:0]   addr,         // byte address
  input  wire [31:0]           wdata,        // write data
  input  wire                  wr,           // write strobe
  input  wire                  rd,           // read strobe
  output reg  [31:0]           rdata,        // read data, cycle after rd
  input  wire [NSEQ-1:0]       conv_done,    // sample finished converting, pulse
  input  wire [NSEQ-1:0]       sample_irq_request, // finished sample asks for an interrupt
  input  wire [NSEQ-1:0]       fifo_full,    // result fifo full
  input  wire [NSEQ-1:0]       fifo_wr_req,  // result write request, pulse
  output wire [NSEQ-1:0]       fifo_wr_en,   // result write accepted
  input  wire                  cpu_req,      // processor sample request
  input  wire                  cmp0_ev,      // comparator 0 event
  input  wire                  pin_ev,       // external trigger pin, asynchronous
  input  wire                  timer_ev,     // timer event
  input  wire [2:0]            pwm_ev,       // pwm events
  output wire [NSEQ-1:0]       seq_start,    // per sequencer sample start
  output wire [NSEQ-1:0]       seq_irq,      // per sequencer level interrupt
  output wire                  irq           // summary event interrupt
);
  reg  [NSEQ-1:0]   irq_forward_enable_q;
  reg  [NSEQ-1:0]   raw_interrupt_status_q;
  reg  [NSEQ-1:0]   fifo_overflow_status_q;
  reg  [4*NSEQ-1:0] trigger_source_select_q;
  reg  [2*NSEQ-1:0] ev_stat_q;
  reg  [2*NSEQ-1:0] ev_mask_q;
  reg  [2:0]        pin_sync_q;
  reg               pin_lvl_q;
  wire [NSEQ-1:0]   masked_irq_status;
  wire [NSEQ-1:0]   raw_set;
  wire [NSEQ-1:0]   ovf_set;
  wire              wr_mask;
  wire              wr_isc;
  wire              wr_ovf;
  wire              wr_trig;
  wire              wr_evst;
  wire              wr_evmk;
  reg  [31:0]       rdata_d;

  assign wr_mask = wr && (addr == `AIOT_OFF_MASK);
  assign wr_isc  = wr && (addr == `AIOT_OFF_ISC);
  assign wr_ovf  = wr && (addr == `AIOT_OFF_OVF);
  assign wr_trig = wr && (addr == `AIOT_OFF_TRIG);
  assign wr_evst = wr && (addr == `AIOT_OFF_EVSTAT);
  assign wr_evmk = wr && (addr == `AIOT_OFF_EVMASK);

  assign raw_set           = conv_done & sample_irq_request;
  assign ovf_set           = fifo_wr_req & fifo_full;
  assign fifo_wr_en        = fifo_wr_req & ~fifo_full;
  assign masked_irq_status = raw_interrupt_status_q & irq_forward_enable_q;
  assign seq_irq           = masked_irq_status;
  assign irq               = |(ev_stat_q & ev_mask_q);

  // pin crosses in; a change counts once stages two and three agree
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_sync_q <= `AIOT_RST3;
      pin_lvl_q  <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], pin_ev};
      if (pin_sync_q[1] == pin_sync_q[2])
        pin_lvl_q <= pin_sync_q[2];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSEQ; g = g + 1) begin : g_seq
      aiot_trig_decode u_dec (
        .sel      (trigger_source_select_q[4*g+3:4*g]),
        .cpu_req  (cpu_req),
        .cmp0_ev  (cmp0_ev),
        .pin_ev   (pin_lvl_q),
        .timer_ev (timer_ev),
        .pwm_ev   (pwm_ev),
        .start    (seq_start[g])
      );
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (rst) begin
      irq_forward_enable_q    <= `AIOT_RST4;
      raw_interrupt_status_q  <= `AIOT_RST4;
      fifo_overflow_status_q  <= `AIOT_RST4;
      trigger_source_select_q <= `AIOT_RST16;
      ev_stat_q               <= `AIOT_RST8;
      ev_mask_q               <= `AIOT_RST8;
    end else begin
      if (wr_mask)
        irq_forward_enable_q <= wdata[`AIOT_SEQ_MSB:`AIOT_SEQ_LSB];
      if (wr_trig)
        trigger_source_select_q <= wdata[`AIOT_TRIG_MSB:0];
      // clear by write-one, set wins over clear
      raw_interrupt_status_q <= (raw_interrupt_status_q
        & ~(wr_isc ? wdata[`AIOT_SEQ_MSB:`AIOT_SEQ_LSB] : 4'h0)) | raw_set;
      fifo_overflow_status_q <= (fifo_overflow_status_q
        & ~(wr_ovf ? wdata[`AIOT_SEQ_MSB:`AIOT_SEQ_LSB] : 4'h0)) | ovf_set;
      ev_stat_q <= (ev_stat_q & ~(wr_evst ? wdata[`AIOT_EV_MSB:0] : `AIOT_RST8)) | {raw_set, ovf_set};
      if (wr_evmk)
        ev_mask_q <= wdata[`AIOT_EV_MSB:0];
    end
  end

  always @* begin
    rdata_d = `AIOT_RST32; // unmapped and reserved bits read zero
    case (addr)
      `AIOT_OFF_RIS:    rdata_d[`AIOT_SEQ_MSB:0] = raw_interrupt_status_q;
      `AIOT_OFF_MASK:   rdata_d[`AIOT_SEQ_MSB:0] = irq_forward_enable_q;
      `AIOT_OFF_ISC:    rdata_d[`AIOT_SEQ_MSB:0] = masked_irq_status;
      `AIOT_OFF_OVF:    rdata_d[`AIOT_SEQ_MSB:0] = fifo_overflow_status_q;
      `AIOT_OFF_TRIG:   rdata_d[`AIOT_TRIG_MSB:0] = trigger_source_select_q;
      `AIOT_OFF_EVSTAT: rdata_d[`AIOT_EV_MSB:0] = ev_stat_q;
      `AIOT_OFF_EVMASK: rdata_d[`AIOT_EV_MSB:0] = ev_mask_q;
      default:          rdata_d = `AIOT_RST32;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst)
      rdata <= `AIOT_RST32;
    else if (rd)
      rdata <= rdata_d;
    else
      rdata <= `AIOT_RST32;
  end
endmodule

// ---- tb/aiot_far.sv ----
`timescale 1ns/1ps
module aiot_far (
  input  wire      clk_sys,   // clock
  output reg [3:0] conv_done, // conversion finished
  output reg [3:0] irq_qual,  // sample asks for irq
  output reg [3:0] fifo_full, // fifo full level
  output reg [3:0] wr_req,    // result write
  output reg [7:0] src        // trigger sources
);
  initial {conv_done, irq_qual, fifo_full, wr_req, src} = 24'h0;
  // released irq_qual and fifo_full lines show the inverse so a stale value cannot pass
  task done(input [3:0] d, input [3:0] q);
    @(posedge clk_sys);
    conv_done <= d;
    irq_qual <= q;
    @(posedge clk_sys);
    conv_done <= 4'h0;
    irq_qual <= ~q;
  endtask
  task ovf(input [3:0] f);
    @(posedge clk_sys);
    fifo_full <= f;
    wr_req <= 4'hf;
    @(posedge clk_sys);
    wr_req <= 4'h0;
    fifo_full <= ~f;
  endtask
  task fire(input int k);
    @(posedge clk_sys);
    src <= 8'h01 << k;
  endtask
endmodule

// ---- tb/aiot_regs_properties.sv ----
`timescale 1ns/1ps
module aiot_chk #(parameter NSEQ = 4) (
  input wire            clk_sys,            // clock
  input wire            rst,                // reset
  input wire [11:0]     addr,               // address
  input wire [31:0]     wdata,              // write data
  input wire            wr,                 // write strobe
  input wire [NSEQ-1:0] conv_done,          // done pulse
  input wire [NSEQ-1:0] sample_irq_request, // qualifier
  input wire [NSEQ-1:0] fifo_full,          // fifo full
  input wire [NSEQ-1:0] fifo_wr_req,        // result write
  input wire [NSEQ-1:0] fifo_wr_en,         // accepted
  input wire            cpu_req,            // cpu trigger
  input wire [NSEQ-1:0] seq_start,          // starts
  input wire [NSEQ-1:0] seq_irq             // level irqs
);
  reg  [NSEQ-1:0] m_q;
  reg  [3:0]      t_q;
  wire            mw  = wr && addr == 12'h008;
  wire [NSEQ-1:0] hit = conv_done & sample_irq_request & m_q;
  wire [NSEQ-1:0] clr_m = wdata[NSEQ-1:0] & ~conv_done;
  always @(posedge clk_sys) begin
    if (rst) begin
      m_q <= '0;
      t_q <= 4'h0;
    end else begin
      if (mw) m_q <= wdata[NSEQ-1:0];
      if (wr && addr == 12'h014) t_q <= wdata[3:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_clr; wr && addr == 12'h00c; endsequence
  property p_wr_en; fifo_wr_en == (fifo_wr_req & ~fifo_full); endproperty
  a_wr_en: assert property (p_wr_en) else $error("bad fifo write enable");
  property p_mask; (seq_irq & ~m_q) == '0; endproperty
  a_mask: assert property (p_mask) else $error("masked irq forwarded");
  property p_raise; |hit && !mw |=> (seq_irq & $past(hit)) == $past(hit); endproperty
  a_raise: assert property (p_raise) else $error("irq not raised");
  property p_hold; !wr |=> (seq_irq & $past(seq_irq)) == $past(seq_irq); endproperty
  a_hold: assert property (p_hold) else $error("irq level dropped");
  property p_clear; s_clr |=> (seq_irq & $past(clr_m)) == '0; endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared");
  property p_cpu; t_q == 4'h0 |-> seq_start[0] == cpu_req; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu trigger wrong");
  property p_always; t_q == 4'hf |-> seq_start[0]; endproperty
  a_always: assert property (p_always) else $error("continuous start missing");
  property p_reset; $fell(rst) |-> seq_irq == '0 && seq_start[0] == cpu_req; endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
bind aiot_regs aiot_chk #(.NSEQ(NSEQ)) aiot_chk_inst (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [11:0] addr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [31:0] rdata;
  wire [3:0] dn, ql, ff, wq, wen, st, si;
  wire [7:0] src;
  wire irq;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  reg [3:0] m, d, q;
  reg [31:0] r;
  always #5 clk_sys = ~clk_sys;
  aiot_regs aiot_regs_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .conv_done(dn), .sample_irq_request(ql), .fifo_full(ff), .fifo_wr_req(wq),
    .fifo_wr_en(wen), .cpu_req(src[0]), .cmp0_ev(src[1]), .pin_ev(src[2]), .timer_ev(src[3]),
    .pwm_ev(src[6:4]), .seq_start(st), .seq_irq(si), .irq(irq));
  aiot_far aiot_far_inst (.clk_sys(clk_sys), .conv_done(dn), .irq_qual(ql), .fifo_full(ff),
    .wr_req(wq), .src(src));
  task chk(input [31:0] g, input [31:0] e);
    #1 checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wreg(input [11:0] a, input [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1; // let flags and comb outputs settle past the taking edge
  endtask
  task rreg(input [11:0] a, input [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1; // rdata is launched by this edge, look once it has settled
    chk(rdata, e);
  endtask
  function automatic [3:0] exp_start(input [15:0] t, input int k);
    for (int i = 0; i < 4; i++) exp_start[i] = t[4*i+:4] == 4'hf || t[4*i+:4] == (k < 2 ? k : k + 2);
  endfunction
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    r = $urandom(32'he02a);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 4; a <= 24; a += 4) rreg(12'(a), 32'h0);
    m = 4'($urandom) | 4'h1;
    wreg(12'h008, {28'h0, m});
    rreg(12'h008, {28'h0, m});
    d = 4'($urandom) | 4'h1;
    q = 4'($urandom) | 4'h1;
    aiot_far_inst.done(d, q);
    rreg(12'h004, {28'h0, d & q});
    rreg(12'h00c, {28'h0, d & q & m});
    chk({28'h0, si}, {28'h0, d & q & m});
    wreg(12'h00c, 32'h0);
    rreg(12'h004, {28'h0, d & q});
    wreg(12'h00c, 32'h0000000f);
    rreg(12'h004, 32'h0);
    aiot_far_inst.done(4'hf, 4'hf);
    wreg(12'h008, 32'h0);
    chk({28'h0, si}, 32'h0);
    wreg(12'h044, 32'h000000ff);
    chk({31'h0, irq}, 32'h1);
    wreg(12'h00c, 32'h0000000f);
    rreg(12'h004, 32'h0);
    wreg(12'h040, 32'h000000ff);
    chk({31'h0, irq}, 32'h0);
    q = 4'($urandom) | 4'h1;
    aiot_far_inst.ovf(q);
    rreg(12'h010, {28'h0, q});
    wreg(12'h010, 32'h1);
    rreg(12'h010, {28'h0, q & 4'he});
    for (int i = 0; i < 16; i++) begin
      r = {16'h0, 4'(i + 3), 4'(i + 2), 4'(i + 1), 4'(i)};
      wreg(12'h014, r);
      rreg(12'h014, r);
      for (int k = 0; k < 7; k++) begin
        aiot_far_inst.fire(k);
        repeat (4) @(posedge clk_sys); // pin path is synchronised first
        #1;
        chk({28'h0, st}, {28'h0, exp_start(r[15:0], k)});
      end
    end
    stop_test;
  end
endmodule
